//--- rtl/mas_pkg.sv
// constants for the arithmetic, skip and table-read execution block
// Overview of operation
// RULE1: minus_into_memory writes accumulator minus byte back to the byte, with four flags.
// RULE2: subtract-immediate puts accumulator minus instruction literal into the accumulator.
// RULE3: borrow_not_flag is 0 for a negative difference, 1 for zero or positive.
// RULE4: subtract-immediate changes sign_wrap, null_result, nibble_half and borrow_not flags only.
// RULE5: nibble swap in place or into accumulator; memory kept for accumulator form; no flags.
// RULE6: skip_when_null skips the next instruction when the byte is zero; no flags.
// RULE7: copy_skip_when_null loads byte into accumulator and skips when zero; no flags.
// RULE8: bit test skips the next instruction when the selected bit is zero.
// RULE9: a taken skip runs one dummy cycle, so the instruction takes two cycles.
// RULE10: table_fetch_paged reads word at page pointer and low pointer; low to byte, high to latch.
// RULE11: table_fetch_current reads current page at low pointer; low to byte, high to latch.
// RULE12: table_fetch_last reads the last page at low pointer; low to byte, high to latch.
// RULE13: accumulator XOR byte into accumulator, changing only null_result_flag.
// RULE14: exclusive_or_into_memory writes accumulator XOR byte to the byte, only null_result_flag.
// RULE15: accumulator XOR literal into accumulator, changing only null_result_flag.
// RULE16: null_result_flag set when an 8-bit flag-affecting result is zero, else cleared.
// RULE17: nibble_half_flag shows no borrow from bit 3; sign_wrap_flag shows signed overflow.
package mas_pkg;

  // operation codes on the op port
  localparam logic [3:0] OP_MINUS_MEM  = 4'h0;
  localparam logic [3:0] OP_MINUS_IMM  = 4'h1;
  localparam logic [3:0] OP_SWAP_MEM   = 4'h2;
  localparam logic [3:0] OP_SWAP_ACC   = 4'h3;
  localparam logic [3:0] OP_SKIP_NULL  = 4'h4;
  localparam logic [3:0] OP_COPY_SKIP  = 4'h5;
  localparam logic [3:0] OP_SKIP_BIT   = 4'h6;
  localparam logic [3:0] OP_TAB_PAGED  = 4'h7;
  localparam logic [3:0] OP_TAB_CUR    = 4'h8;
  localparam logic [3:0] OP_TAB_LAST   = 4'h9;
  localparam logic [3:0] OP_XOR_ACC    = 4'ha;
  localparam logic [3:0] OP_XOR_MEM    = 4'hb;
  localparam logic [3:0] OP_XOR_IMM    = 4'hc;

  // register byte addresses on the bus
  localparam logic [7:0] ADR_ACC    = 8'h00;
  localparam logic [7:0] ADR_FLAGS  = 8'h04;
  localparam logic [7:0] ADR_LOWPTR = 8'h08;
  localparam logic [7:0] ADR_PAGE   = 8'h0c;
  localparam logic [7:0] ADR_HIGH   = 8'h10;

  // flag bit positions in the flag register
  localparam int FLG_BORROW_NOT = 0;
  localparam int FLG_NIBBLE     = 1;
  localparam int FLG_NULL       = 2;
  localparam int FLG_SIGN_WRAP  = 3;
  localparam int FLG_W          = 4;

  // reset values
  localparam logic [7:0]       RST_BYTE  = 8'h00;
  localparam logic [FLG_W-1:0] RST_FLAGS = 4'h0;

  // byte layout helpers
  localparam int BYTE_MSB = 7;
  localparam int NIB_MSB  = 3;
  localparam int NIB_LSB  = 4;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TREAD,
    ST_DUMMY
  } mas_state_t;

endpackage

//--- rtl/mas_alu.sv
// execution datapath for subtract, swap, skip, table read and exclusive-or
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module mas_alu #(
  parameter int PAW = 11                       // program address width
) (
  input  wire logic           CORE_CLK,        // core clock
  input  wire logic           SYS_RST,         // sync reset, active high
  input  wire logic           CLK_EN,          // freezes all state when low
  input  wire logic           WB_CYC_I,        // wishbone cycle
  input  wire logic           WB_STB_I,        // wishbone strobe
  input  wire logic           WB_WE_I,         // wishbone write
  input  wire logic [7:0]     WB_ADR_I,        // wishbone byte address
  input  wire logic [3:0]     WB_SEL_I,        // wishbone byte enables
  input  wire logic [31:0]    WB_DAT_I,        // wishbone write data
  output logic      [31:0]    WB_DAT_O,        // wishbone read data
  output logic                WB_ACK_O,        // wishbone ack
  input  wire logic           OP_VALID,        // operation offered
  output logic                OP_READY,        // operation accepted when high
  input  wire logic [3:0]     OP_CODE,         // operation code
  input  wire logic [7:0]     OP_LIT,          // instruction literal
  input  wire logic [2:0]     OP_BIT,          // bit select for bit test
  input  wire logic [7:0]     MEM_RDATA,       // addressed data byte
  input  wire logic [PAW-9:0] PC_PAGE,         // current program page
  output logic      [7:0]     MEM_WDATA,       // byte written back
  output logic                MEM_WE,          // write-back strobe
  output logic      [PAW-1:0] PROG_ADDR,       // program memory address
  input  wire logic [15:0]    PROG_DATA,       // program word
  output logic                OP_DONE,         // operation finished
  output logic                SKIP_TAKEN,      // next instruction skipped
  output logic                DUMMY_CYCLE,     // dummy cycle in progress
  output logic      [7:0]     ACC_OUT,         // accumulator
  output logic      [3:0]     FLAGS_OUT        // flag register
);

  localparam int PGW = PAW - 8;
  localparam logic [PGW-1:0] LAST_PAGE = '1;

  mas_pkg::mas_state_t state_q;
  mas_pkg::mas_state_t state_d;

  logic [7:0]     acc_q;
  logic [3:0]     flags_q;
  logic [7:0]     lowptr_q;
  logic [PGW-1:0] page_q;
  logic [7:0]     high_q;
  logic [7:0]     mem_wdata_q;
  logic           mem_we_q;
  logic [PAW-1:0] prog_addr_q;
  logic           done_q;
  logic           skip_q;
  logic           ack_q;
  logic [31:0]    rdata_q;

  logic           take;
  logic           wb_req;
  logic           wb_wr;
  logic [8:0]     diff;
  logic [4:0]     ndiff;
  logic [7:0]     sub_b;
  logic [7:0]     xor_b;
  logic [7:0]     xor_r;
  logic [7:0]     swapped;
  logic           is_sub;
  logic           is_xor;
  logic           skip_hit;
  logic           wrap;

  // handshake and bus qualifiers
  assign OP_READY = (state_q == mas_pkg::ST_IDLE);
  assign take     = CLK_EN && OP_VALID && OP_READY;
  assign wb_req   = WB_CYC_I && WB_STB_I;
  assign wb_wr    = wb_req && WB_WE_I && ack_q && WB_SEL_I[0];

  // subtraction datapath, nine bits keep the borrow
  assign is_sub  = (OP_CODE == mas_pkg::OP_MINUS_MEM) || (OP_CODE == mas_pkg::OP_MINUS_IMM);
  assign sub_b   = (OP_CODE == mas_pkg::OP_MINUS_IMM) ? OP_LIT : MEM_RDATA;
  assign diff    = {1'b0, acc_q} - {1'b0, sub_b};
  assign ndiff   = {1'b0, acc_q[mas_pkg::NIB_MSB:0]} - {1'b0, sub_b[mas_pkg::NIB_MSB:0]};
  // operands of differing sign and result sign unlike minuend
  assign wrap    = (acc_q[mas_pkg::BYTE_MSB] != sub_b[mas_pkg::BYTE_MSB]) &&
                   (diff[mas_pkg::BYTE_MSB] != acc_q[mas_pkg::BYTE_MSB]); // RULE17

  // exclusive-or and swap datapath
  assign is_xor  = (OP_CODE == mas_pkg::OP_XOR_ACC) || (OP_CODE == mas_pkg::OP_XOR_MEM) ||
                   (OP_CODE == mas_pkg::OP_XOR_IMM);
  assign xor_b   = (OP_CODE == mas_pkg::OP_XOR_IMM) ? OP_LIT : MEM_RDATA;
  assign xor_r   = acc_q ^ xor_b;
  assign swapped = {MEM_RDATA[mas_pkg::NIB_MSB:0], MEM_RDATA[mas_pkg::BYTE_MSB:mas_pkg::NIB_LSB]};

  // skip decision for the three test forms
  always_comb begin
    skip_hit = 1'b0;
    case (OP_CODE)
      mas_pkg::OP_SKIP_NULL: skip_hit = (MEM_RDATA == 8'h00); // RULE6
      mas_pkg::OP_COPY_SKIP: skip_hit = (MEM_RDATA == 8'h00); // RULE7
      mas_pkg::OP_SKIP_BIT:  skip_hit = ~MEM_RDATA[OP_BIT];   // RULE8
      default:               skip_hit = 1'b0;
    endcase
  end

  // sequencer: table reads wait one cycle, taken skips add a dummy cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      mas_pkg::ST_IDLE: begin
        if (take && (OP_CODE == mas_pkg::OP_TAB_PAGED || OP_CODE == mas_pkg::OP_TAB_CUR ||
                     OP_CODE == mas_pkg::OP_TAB_LAST)) begin
          state_d = mas_pkg::ST_TREAD;
        end else if (take && skip_hit) begin
          state_d = mas_pkg::ST_DUMMY; // RULE9
        end
      end
      mas_pkg::ST_TREAD: state_d = mas_pkg::ST_IDLE;
      mas_pkg::ST_DUMMY: state_d = mas_pkg::ST_IDLE; // RULE9
      default:           state_d = mas_pkg::ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      state_q <= mas_pkg::ST_IDLE;
    end else if (CLK_EN) begin
      state_q <= state_d;
    end
  end

  // accumulator, op result wins over a bus write in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      acc_q <= mas_pkg::RST_BYTE;
    end else if (CLK_EN) begin
      if (take && OP_CODE == mas_pkg::OP_MINUS_IMM) begin
        acc_q <= diff[7:0]; // RULE2
      end else if (take && OP_CODE == mas_pkg::OP_SWAP_ACC) begin
        acc_q <= swapped; // RULE5
      end else if (take && OP_CODE == mas_pkg::OP_COPY_SKIP) begin
        acc_q <= MEM_RDATA; // RULE7
      end else if (take && (OP_CODE == mas_pkg::OP_XOR_ACC || OP_CODE == mas_pkg::OP_XOR_IMM)) begin
        acc_q <= xor_r; // RULE13 RULE15
      end else if (wb_wr && WB_ADR_I == mas_pkg::ADR_ACC) begin
        acc_q <= WB_DAT_I[7:0];
      end
    end
  end

  // flags: subtracts touch four, exclusive-ors touch only the null flag
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      flags_q <= mas_pkg::RST_FLAGS;
    end else if (CLK_EN) begin
      if (take && is_sub) begin
        flags_q[mas_pkg::FLG_BORROW_NOT] <= ~diff[8];              // RULE1 RULE3 RULE4
        flags_q[mas_pkg::FLG_NIBBLE]     <= ~ndiff[4];             // RULE17
        flags_q[mas_pkg::FLG_NULL]       <= (diff[7:0] == 8'h00);  // RULE16
        flags_q[mas_pkg::FLG_SIGN_WRAP]  <= wrap;                  // RULE17
      end else if (take && is_xor) begin
        flags_q[mas_pkg::FLG_NULL] <= (xor_r == 8'h00); // RULE13 RULE14 RULE15 RULE16
      end else if (wb_wr && WB_ADR_I == mas_pkg::ADR_FLAGS) begin
        flags_q <= WB_DAT_I[mas_pkg::FLG_W-1:0];
      end
    end
  end

  // table pointers, written by software only
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      lowptr_q <= mas_pkg::RST_BYTE;
      page_q   <= '0;
    end else if (CLK_EN) begin
      if (wb_wr && WB_ADR_I == mas_pkg::ADR_LOWPTR) begin
        lowptr_q <= WB_DAT_I[7:0];
      end
      if (wb_wr && WB_ADR_I == mas_pkg::ADR_PAGE) begin
        page_q <= WB_DAT_I[PGW-1:0];
      end
    end
  end

  // program address for the three table page choices
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      prog_addr_q <= '0;
    end else if (CLK_EN && take) begin
      case (OP_CODE)
        mas_pkg::OP_TAB_PAGED: prog_addr_q <= {page_q, lowptr_q};    // RULE10
        mas_pkg::OP_TAB_CUR:   prog_addr_q <= {PC_PAGE, lowptr_q};   // RULE11
        mas_pkg::OP_TAB_LAST:  prog_addr_q <= {LAST_PAGE, lowptr_q}; // RULE12
        default:               prog_addr_q <= prog_addr_q;
      endcase
    end
  end

  // high byte latch, loaded from the fetched program word
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      high_q <= mas_pkg::RST_BYTE;
    end else if (CLK_EN && state_q == mas_pkg::ST_TREAD) begin
      high_q <= PROG_DATA[15:8]; // RULE10 RULE11 RULE12
    end
  end

  // data memory write-back
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mem_we_q    <= 1'b0;
      mem_wdata_q <= mas_pkg::RST_BYTE;
    end else if (CLK_EN) begin
      mem_we_q <= 1'b0;
      if (state_q == mas_pkg::ST_TREAD) begin
        mem_we_q    <= 1'b1;
        mem_wdata_q <= PROG_DATA[7:0]; // RULE10 RULE11 RULE12
      end else if (take && OP_CODE == mas_pkg::OP_MINUS_MEM) begin
        mem_we_q    <= 1'b1;
        mem_wdata_q <= diff[7:0]; // RULE1
      end else if (take && OP_CODE == mas_pkg::OP_SWAP_MEM) begin
        mem_we_q    <= 1'b1;
        mem_wdata_q <= swapped; // RULE5
      end else if (take && OP_CODE == mas_pkg::OP_XOR_MEM) begin
        mem_we_q    <= 1'b1;
        mem_wdata_q <= xor_r; // RULE14
      end
    end
  end

  // completion and skip indications
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      done_q <= 1'b0;
      skip_q <= 1'b0;
    end else if (CLK_EN) begin
      skip_q <= take && skip_hit;
      done_q <= (take && !skip_hit && state_d == mas_pkg::ST_IDLE) ||
                (state_q != mas_pkg::ST_IDLE); // RULE9
    end
  end

  // wishbone slave: ack one cycle after request, dropped the cycle after
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (CLK_EN) begin
      ack_q <= wb_req && !ack_q;
      if (wb_req && !ack_q) begin
        case (WB_ADR_I)
          mas_pkg::ADR_ACC:    rdata_q <= {24'h000000, acc_q};
          mas_pkg::ADR_FLAGS:  rdata_q <= {28'h0000000, flags_q};
          mas_pkg::ADR_LOWPTR: rdata_q <= {24'h000000, lowptr_q};
          mas_pkg::ADR_PAGE:   rdata_q <= {{(32-PGW){1'b0}}, page_q};
          mas_pkg::ADR_HIGH:   rdata_q <= {24'h000000, high_q};
          default:             rdata_q <= '0;
        endcase
      end
    end
  end

  // outputs
  assign WB_DAT_O    = rdata_q;
  assign WB_ACK_O    = ack_q;
  assign MEM_WDATA   = mem_wdata_q;
  assign MEM_WE      = mem_we_q;
  assign PROG_ADDR   = prog_addr_q;
  assign OP_DONE     = done_q;
  assign SKIP_TAKEN  = skip_q;
  assign DUMMY_CYCLE = (state_q == mas_pkg::ST_DUMMY);
  assign ACC_OUT     = acc_q;
  assign FLAGS_OUT   = flags_q;

endmodule

//--- verif/mas_alu_monitor.sv
// checker for the execution block ports
`timescale 1ns/10ps
module mas_alu_monitor #(
  parameter int PAW = 11 // address width
) (
  input wire logic           CORE_CLK,    // clock
  input wire logic           SYS_RST,     // reset
  input wire logic           CLK_EN,      // enable
  input wire logic           OP_VALID,    // offered
  input wire logic           OP_READY,    // ready
  input wire logic [3:0]     OP_CODE,     // code
  input wire logic [7:0]     OP_LIT,      // literal
  input wire logic [7:0]     MEM_RDATA,   // byte in
  input wire logic [7:0]     MEM_WDATA,   // byte out
  input wire logic           MEM_WE,      // byte write
  input wire logic [PAW-1:0] PROG_ADDR,   // rom address
  input wire logic [15:0]    PROG_DATA,   // rom word
  input wire logic           OP_DONE,     // done
  input wire logic           SKIP_TAKEN,  // skip
  input wire logic           DUMMY_CYCLE, // dummy
  input wire logic [7:0]     ACC_OUT,     // accumulator
  input wire logic [3:0]     FLAGS_OUT    // flags
);
  logic [3:0] c;
  // accepted code, else an unused one
  assign c = (OP_VALID && OP_READY && CLK_EN) ? OP_CODE : 4'hf;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  AST_SUB_MEM: assert property (c == mas_pkg::OP_MINUS_MEM
    |=> MEM_WE && MEM_WDATA == $past(ACC_OUT) - $past(MEM_RDATA)) else $error("bad difference");
  AST_SUB_IMM: assert property (c == mas_pkg::OP_MINUS_IMM
    |=> ACC_OUT == $past(ACC_OUT) - $past(OP_LIT) && FLAGS_OUT[0] == ($past(ACC_OUT) >= $past(OP_LIT)))
    else $error("bad immediate difference");
  AST_XOR_IMM: assert property (c == mas_pkg::OP_XOR_IMM
    |=> ACC_OUT == ($past(ACC_OUT) ^ $past(OP_LIT)) && FLAGS_OUT[2] == (ACC_OUT == 8'h00)
    && FLAGS_OUT[1:0] == $past(FLAGS_OUT[1:0])) else $error("bad xor");
  AST_SWAP_ACC: assert property (c == mas_pkg::OP_SWAP_ACC
    |=> ACC_OUT == {$past(MEM_RDATA[3:0]), $past(MEM_RDATA[7:4])} && !MEM_WE && $stable(FLAGS_OUT))
    else $error("bad swap");
  AST_SKIP_NULL: assert property (c == mas_pkg::OP_SKIP_NULL
    |=> SKIP_TAKEN == ($past(MEM_RDATA) == 8'h00) && $stable(FLAGS_OUT)) else $error("bad skip");
  AST_DUMMY: assert property (SKIP_TAKEN
    |-> DUMMY_CYCLE && !OP_READY ##1 OP_DONE) else $error("bad dummy cycle");
  AST_TAB_LAST: assert property (c == mas_pkg::OP_TAB_LAST
    |=> &PROG_ADDR[PAW-1:8]) else $error("bad last page");
  AST_TAB_DATA: assert property (c inside {[mas_pkg::OP_TAB_PAGED:mas_pkg::OP_TAB_LAST]}
    ##1 1'b1 |=> MEM_WE && MEM_WDATA == $past(PROG_DATA[7:0])) else $error("bad table byte");
  cover property (SKIP_TAKEN ##1 OP_DONE);
  cover property (c == mas_pkg::OP_TAB_CUR);
  cover property (c == mas_pkg::OP_MINUS_MEM);
endmodule
bind mas_alu mas_alu_monitor #(.PAW(PAW)) mon_i (.*);

//--- verif/tb.sv
// self-checking bench for the execution block
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  logic        CORE_CLK = 1'b0, SYS_RST = 1'b1, CLK_EN = 1'b1, WB_CYC_I = 1'b0;
  logic        WB_WE_I = 1'b0, OP_VALID = 1'b0, WB_STB_I, WB_ACK_O, OP_READY, MEM_WE;
  logic        OP_DONE, SKIP_TAKEN, DUMMY_CYCLE;
  logic [2:0]  OP_BIT = 3'h0, PC_PAGE = 3'h2;
  logic [3:0]  WB_SEL_I = 4'hf, OP_CODE = 4'h0, FLAGS_OUT;
  logic [7:0]  WB_ADR_I = 8'h00, OP_LIT = 8'h00, MEM_RDATA = 8'h00, MEM_WDATA, ACC_OUT;
  logic [10:0] PROG_ADDR;
  logic [15:0] PROG_DATA;
  logic [31:0] WB_DAT_I = 32'h0, WB_DAT_O;
  int          err_count, total_checks;
  mas_alu mas_alu_i (.*);
  // rom word derived from its own address
  assign PROG_DATA = {5'h00, PROG_ADDR} ^ 16'hc3a5;
  assign WB_STB_I  = WB_CYC_I;
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge CORE_CLK);
    WB_CYC_I <= 1'b1;
    WB_WE_I  <= we;
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 20);
    q = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    if (WB_ACK_O !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, {24'h0, d}, q);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    `CHK(q, e)
  endtask
  // one operation; bit select rides in the literal's low bits
  task automatic run(input logic [3:0] c, input logic [7:0] l, m, input int el,
                     input logic es, input logic [7:0] ew, ea, input logic [3:0] ef);
    int         lat;
    logic       sk;
    logic [7:0] wd;
    lat = 0;
    sk  = 1'b0;
    wd  = 8'hee;
    @(posedge CORE_CLK);
    OP_VALID  <= 1'b1;
    OP_CODE   <= c;
    OP_LIT    <= l;
    OP_BIT    <= l[2:0];
    MEM_RDATA <= m;
    @(posedge CORE_CLK);
    OP_VALID <= 1'b0;
    do begin
      @(posedge CORE_CLK);
      lat++;
      if (SKIP_TAKEN === 1'b1) sk = 1'b1;
      if (MEM_WE === 1'b1) wd = MEM_WDATA;
    end while (OP_DONE !== 1'b1 && lat < 8);
    if (OP_DONE !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    `CHK(lat, el)
    `CHK(sk, es)
    `CHK(wd, ew)
    `CHK(ACC_OUT, ea)
    `CHK(FLAGS_OUT, ef)
  endtask
  // reset values, read-only latch, unmapped place, writable registers
  task automatic t_regs;
    rchk(mas_pkg::ADR_ACC, 32'h0);
    rchk(mas_pkg::ADR_FLAGS, 32'h0);
    wr(mas_pkg::ADR_HIGH, 8'hff);
    rchk(mas_pkg::ADR_HIGH, 32'h0);
    rchk(8'h20, 32'h0);
    wr(mas_pkg::ADR_FLAGS, 8'h0f);
    rchk(mas_pkg::ADR_FLAGS, 32'h0000000f);
    wr(mas_pkg::ADR_ACC, 8'h10);
  endtask
  task automatic t_sub;
    run(mas_pkg::OP_MINUS_MEM, 8'h00, 8'h20, 1, 1'b0, 8'hf0, 8'h10, 4'h2);
    wr(mas_pkg::ADR_ACC, 8'h80);
    run(mas_pkg::OP_MINUS_IMM, 8'h01, 8'h00, 1, 1'b0, 8'hee, 8'h7f, 4'h9);
    run(mas_pkg::OP_MINUS_IMM, 8'h7f, 8'h00, 1, 1'b0, 8'hee, 8'h00, 4'h7);
  endtask
  task automatic t_xor;
    run(mas_pkg::OP_XOR_ACC, 8'h00, 8'h5a, 1, 1'b0, 8'hee, 8'h5a, 4'h3);
    run(mas_pkg::OP_XOR_MEM, 8'h00, 8'h5a, 1, 1'b0, 8'h00, 8'h5a, 4'h7);
    run(mas_pkg::OP_XOR_IMM, 8'hff, 8'h00, 1, 1'b0, 8'hee, 8'ha5, 4'h3);
  endtask
  task automatic t_swap;
    run(mas_pkg::OP_SWAP_MEM, 8'h00, 8'h3c, 1, 1'b0, 8'hc3, 8'ha5, 4'h3);
    run(mas_pkg::OP_SWAP_ACC, 8'h00, 8'h3c, 1, 1'b0, 8'hee, 8'hc3, 4'h3);
  endtask
  task automatic t_skip;
    run(mas_pkg::OP_SKIP_NULL, 8'h00, 8'h00, 2, 1'b1, 8'hee, 8'hc3, 4'h3);
    run(mas_pkg::OP_SKIP_NULL, 8'h00, 8'h01, 1, 1'b0, 8'hee, 8'hc3, 4'h3);
    run(mas_pkg::OP_COPY_SKIP, 8'h00, 8'h00, 2, 1'b1, 8'hee, 8'h00, 4'h3);
    run(mas_pkg::OP_COPY_SKIP, 8'h00, 8'h81, 1, 1'b0, 8'hee, 8'h81, 4'h3);
    run(mas_pkg::OP_SKIP_BIT, 8'h00, 8'hfe, 2, 1'b1, 8'hee, 8'h81, 4'h3);
    run(mas_pkg::OP_SKIP_BIT, 8'h01, 8'hfe, 1, 1'b0, 8'hee, 8'h81, 4'h3);
    run(mas_pkg::OP_SKIP_BIT, 8'h07, 8'h7f, 2, 1'b1, 8'hee, 8'h81, 4'h3);
  endtask
  // paged, current and last page reads of the same offset
  task automatic t_table;
    logic [3:0] cd [3] = '{mas_pkg::OP_TAB_PAGED, mas_pkg::OP_TAB_CUR, mas_pkg::OP_TAB_LAST};
    logic [2:0] pg [3] = '{3'h5, 3'h2, 3'h7};
    wr(mas_pkg::ADR_LOWPTR, 8'h34);
    wr(mas_pkg::ADR_PAGE, 8'h05);
    for (int i = 0; i < 3; i++) begin
      run(cd[i], 8'h00, 8'h00, 2, 1'b0, 8'h91, 8'h81, 4'h3);
      rchk(mas_pkg::ADR_HIGH, {24'h0, 8'hc3 ^ {5'h00, pg[i]}});
    end
  endtask
  // enable low: an offered op must neither act nor finish
  task automatic t_freeze;
    @(posedge CORE_CLK);
    CLK_EN   <= 1'b0;
    OP_VALID <= 1'b1;
    OP_CODE  <= mas_pkg::OP_XOR_IMM;
    OP_LIT   <= 8'hff;
    repeat (3) @(posedge CORE_CLK);
    `CHK(ACC_OUT, 8'h81)
    `CHK(OP_DONE, 1'b0)
    OP_VALID <= 1'b0;
    CLK_EN   <= 1'b1;
    @(posedge CORE_CLK);
  endtask
  // reset, then every scenario in turn
  initial begin
    repeat (10) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_sub();
    t_xor();
    t_swap();
    t_skip();
    t_table();
    t_freeze();
    give_verdict();
  end
endmodule
